// *** dbp_bank.v ***
/*
  One bank of the port: three output holding registers (A, B, C)
  and the per-pin drive enables and read-back values.
  Assumes the parent decodes the bus and gives one-cycle write strobes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dbp_consts.vh"

module dbp_bank (
  // clock and reset
  input  wire        i_mclk,
  input  wire        i_resetn,
  // write strobes and data
  input  wire [2:0]  i_wr,
  input  wire [7:0]  i_wdata,
  // direction control byte
  input  wire [7:0]  i_ctrl,
  // pin levels
  input  wire [23:0] i_pin,
  // drive and read-back
  output wire [23:0] o_dout,
  output wire [23:0] o_doe,
  output wire [23:0] o_rdval
);

  wire [23:0] hold;
  wire [23:0] in_sel;
  genvar      g;

  // one input flag per nibble: A lo/hi, B lo/hi, C lo/hi
  wire [5:0] nib_in;
  assign nib_in = {i_ctrl[`DBP_DIR_PORTC_HI], i_ctrl[`DBP_DIR_PORTC_LO],
                   i_ctrl[`DBP_DIR_PORTB], i_ctrl[`DBP_DIR_PORTB],
                   i_ctrl[`DBP_DIR_PORTA], i_ctrl[`DBP_DIR_PORTA]};

  generate
    for (g = 0; g < 3; g = g + 1) begin : g_port
      // one register per port keeps a single driver for each bit
      reg [7:0] port_r;
      // holding register writable whatever the direction (see [R3])
      // bits of an input nibble are stored only (see [R10])
      always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
          port_r <= 8'h00;
        end else if (i_wr[g]) begin
          port_r <= i_wdata;
        end
      end
      assign hold[g*8+7:g*8] = port_r;
    end
    for (g = 0; g < 6; g = g + 1) begin : g_nib
      assign in_sel[g*4+3:g*4] = {4{nib_in[g]}};
    end
  endgenerate

  // stored value drives as soon as direction turns to output (see [R4])
  assign o_dout  = hold;
  assign o_doe   = ~in_sel;                                   // see [R1] see [R7]
  // input nibbles read pins, output nibbles read drive (see [R9] see [R8] see [R14])
  assign o_rdval = (i_pin & in_sel) | (hold & ~in_sel);

endmodule
`default_nettype wire

// *** dbp_chk_asserts.sv ***
/* checker for the port block: bus answer, drive enables, pin reads
   assumes a bind onto dbp_top with one clock and async low reset */
`timescale 1ns/1ps
`default_nettype none
module dbp_chk (
  input wire logic        i_mclk, i_resetn, i_wb_cyc, i_wb_stb, i_wb_we,
  input wire logic [5:0]  i_wb_adr,
  input wire logic [3:0]  i_wb_sel,
  input wire logic [31:0] i_wb_dat, o_wb_dat,
  input wire logic        o_wb_ack, o_irq,
  input wire logic [23:0] i_bank1_pin, o_bank1_dout, o_bank1_doe,
  input wire logic [23:0] i_bank2_pin, o_bank2_dout, o_bank2_doe
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  wire take = i_wb_cyc && i_wb_stb && !o_wb_ack;
  wire wr0  = take && i_wb_we && i_wb_sel[0];
  a_ack_once: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held too long");
  a_ack_next: assert property (take |=> o_wb_ack)
    else $error("ack late");
  a_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("read data outside ack");
  a_dat_upper: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0)
    else $error("upper read bits set");
  a_doe_group: assert property (o_bank1_doe[23:20] inside {4'h0, 4'hF} &&
    o_bank1_doe[19:16] inside {4'h0, 4'hF} && o_bank2_doe[7:0] inside {8'h00, 8'hFF})
    else $error("drive enable group split");
  a_hold_write: assert property (wr0 && i_wb_adr == 6'h00 |->
    ##2 o_bank1_dout[7:0] == $past(i_wb_dat[7:0], 2)) else $error("holding reg not written");
  a_ctrl_doe: assert property (wr0 && i_wb_adr == 6'h0C |->
    ##2 o_bank1_doe[7:0] == {8{!$past(i_wb_dat[4], 2)}}) else $error("port a enable wrong");
  a_read_pins: assert property (take && !i_wb_we && i_wb_adr == 6'h00 &&
    o_bank1_doe[7:0] == 8'h00 |=> o_wb_dat[7:0] == $past(i_bank1_pin[7:0]))
    else $error("input read wrong");
endmodule
bind dbp_top dbp_chk u_chk (
  .i_mclk(i_mclk), .i_resetn(i_resetn), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_irq(o_irq),
  .i_bank1_pin(i_bank1_pin), .o_bank1_dout(o_bank1_dout), .o_bank1_doe(o_bank1_doe),
  .i_bank2_pin(i_bank2_pin), .o_bank2_dout(o_bank2_dout), .o_bank2_doe(o_bank2_doe)
);
`default_nettype wire

// *** dbp_consts.vh ***
/*
  Constants for the dual bank parallel I/O port: register offsets,
  control word field positions, reset values and interrupt bits.
  Assumes inclusion by the design files of the port block only.
*/
`ifndef DBP_CONSTS_VH
`define DBP_CONSTS_VH

// byte offsets of the port registers (one 32-bit word each)
`define DBP_OFF_B1_PORTA    6'h00
`define DBP_OFF_B1_PORTB    6'h04
`define DBP_OFF_B1_PORTC    6'h08
`define DBP_OFF_B2_PORTA    6'h20
`define DBP_OFF_B2_PORTB    6'h24
`define DBP_OFF_B2_PORTC    6'h28
// control words and interrupt registers
`define DBP_OFF_CTRL0       6'h0C
`define DBP_OFF_CTRL1       6'h2C
`define DBP_OFF_IRQ_STAT    6'h30
`define DBP_OFF_IRQ_MASK    6'h34
`define DBP_OFF_IRQ_CTRL    6'h38

// control word direction bits (1 = input)
`define DBP_DIR_PORTC_LO    0
`define DBP_DIR_PORTB       1
`define DBP_DIR_PORTC_HI    3
`define DBP_DIR_PORTA       4
`define DBP_CTRL_FIXED_ONE  7
`define DBP_CTRL_RESET      8'h9B

// interrupt fields
`define DBP_IRQ_SRC_BIT     0
`define DBP_IRQ_EN_BIT      0
`define DBP_IRQ_EDGE_BIT    1
`define DBP_IRQ_CTRL_RESET  2'h0

`endif

// *** dbp_pins.sv ***
/* far-side model: switches and sensors on the port pins
   assumes the bench sets what the switches drive; idle lines held high */
`timescale 1ns/1ps
`default_nettype none
module dbp_pins (
  // drive side
  input  wire logic [23:0] i_dout,
  input  wire logic [23:0] i_doe,
  // switch levels
  input  wire logic [23:0] i_ext,
  output wire logic [23:0] o_pin
);
  // a driven line shows the drive value, the rest show the switches
  assign o_pin = (i_doe & i_dout) | (~i_doe & i_ext);
endmodule
`default_nettype wire

// *** dbp_top.v ***
/*
  Dual bank 48-line parallel I/O port with a classic Wishbone slave
  and one level interrupt output.
  Assumes pins sampled synchronously to i_mclk; the host assigns the base,
  so only the low address bits are decoded here.

  // Summary of operation
  // [R1] Forty-eight lines in six ports, each port group set to input or output by its control bits.
  // [R2] The host assigns the base address and interrupt line; the block decodes relative offsets.
  // [R3] Every port has an output holding register writable at any time regardless of direction.
  // [R4] The holding register survives direction changes and drives at once when made output.
  // [R5] Software should preset the value while input and then switch the port to output.
  // [R6] Bit 0 of bank 1 port A is the only interrupt source, with software-enabled sampling.
  // [R7] Port C halves of each bank have independent directions.
  // [R8] With both halves alike port C behaves like an ordinary eight-bit port.
  // [R9] A read of split port C gives pins in the input half and driven values in the output half.
  // [R10] A write to split port C drives the output half and only stores the input half.
  // [R11] Software uses whole-byte accesses to split port C and tracks each half's direction.
  // [R12] Control bits 4, 1, 0, 3 set ports A, B, C low, C high; 1 is input, reset to input.
  // [R13] Control word 0 governs bank 1 and control word 1 governs bank 2.
  // [R14] Inputs read with positive polarity.
  // [R15] The interrupt source is synchronised and its active edge latches a sticky pending flag.
*/
// Chosen here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "dbp_consts.vh"

module dbp_top (
  // clock and reset
  input  wire        i_mclk,
  input  wire        i_resetn,
  // wishbone slave
  input  wire        i_wb_cyc,
  input  wire        i_wb_stb,
  input  wire        i_wb_we,
  input  wire [5:0]  i_wb_adr,
  input  wire [3:0]  i_wb_sel,
  input  wire [31:0] i_wb_dat,
  output reg  [31:0] o_wb_dat,
  output reg         o_wb_ack,
  // bank pins
  input  wire [23:0] i_bank1_pin,
  output reg  [23:0] o_bank1_dout,
  output reg  [23:0] o_bank1_doe,
  input  wire [23:0] i_bank2_pin,
  output reg  [23:0] o_bank2_dout,
  output reg  [23:0] o_bank2_doe,
  // interrupt
  output reg         o_irq
);

  reg  [7:0]  ctrl0_r;
  reg  [7:0]  ctrl1_r;
  reg  [1:0]  irq_ctrl_r;
  reg         irq_stat_r;
  reg         irq_mask_r;
  reg         src_s1_r;
  reg         src_s2_r;
  reg         src_d_r;
  reg  [31:0] rd_nxt;
  wire        req;
  wire        wr;
  wire        rd;
  wire [2:0]  wr_b1;
  wire [2:0]  wr_b2;
  wire [23:0] b1_dout;
  wire [23:0] b1_doe;
  wire [23:0] b1_rd;
  wire [23:0] b2_dout;
  wire [23:0] b2_doe;
  wire [23:0] b2_rd;
  wire        src_edge;
  wire        ev_set;

  // one-cycle ack, so each request completes in two cycles
  assign req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr  = req & i_wb_we & i_wb_sel[0];
  assign rd  = req & ~i_wb_we;

  // offsets are relative to the host-assigned base (see [R2])
  assign wr_b1 = {wr & (i_wb_adr == `DBP_OFF_B1_PORTC),
                  wr & (i_wb_adr == `DBP_OFF_B1_PORTB),
                  wr & (i_wb_adr == `DBP_OFF_B1_PORTA)};
  assign wr_b2 = {wr & (i_wb_adr == `DBP_OFF_B2_PORTC),
                  wr & (i_wb_adr == `DBP_OFF_B2_PORTB),
                  wr & (i_wb_adr == `DBP_OFF_B2_PORTA)};

  // bank 1 under control word 0, bank 2 under control word 1 (see [R13])
  dbp_bank u_bank1 (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_wr     (wr_b1),
    .i_wdata  (i_wb_dat[7:0]),
    .i_ctrl   (ctrl0_r),
    .i_pin    (i_bank1_pin),
    .o_dout   (b1_dout),
    .o_doe    (b1_doe),
    .o_rdval  (b1_rd)
  );

  dbp_bank u_bank2 (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_wr     (wr_b2),
    .i_wdata  (i_wb_dat[7:0]),
    .i_ctrl   (ctrl1_r),
    .i_pin    (i_bank2_pin),
    .o_dout   (b2_dout),
    .o_doe    (b2_doe),
    .o_rdval  (b2_rd)
  );

  // control words; bit 7 always reads one, all direction bits reset to input
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl0_r    <= `DBP_CTRL_RESET;                           // see [R12]
      ctrl1_r    <= `DBP_CTRL_RESET;
      irq_ctrl_r <= `DBP_IRQ_CTRL_RESET;
      irq_mask_r <= 1'b0;
    end else if (wr) begin
      if (i_wb_adr == `DBP_OFF_CTRL0) begin
        ctrl0_r <= i_wb_dat[7:0] | 8'h80;                      // see [R12] see [R1]
      end
      if (i_wb_adr == `DBP_OFF_CTRL1) begin
        ctrl1_r <= i_wb_dat[7:0] | 8'h80;
      end
      if (i_wb_adr == `DBP_OFF_IRQ_CTRL) begin
        irq_ctrl_r <= i_wb_dat[1:0];
      end
      if (i_wb_adr == `DBP_OFF_IRQ_MASK) begin
        irq_mask_r <= i_wb_dat[0];
      end
    end
  end

  // two-flop synchroniser; only the second stage feeds the edge detector
  // reset to the pulled-up idle level so release gives no false edge
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      src_s1_r <= 1'b1;
      src_s2_r <= 1'b1;
      src_d_r  <= 1'b1;
    end else begin
      src_s1_r <= i_bank1_pin[`DBP_IRQ_SRC_BIT];               // see [R6]
      src_s2_r <= src_s1_r;
      src_d_r  <= src_s2_r;
    end
  end

  // edge bit selects rising (0) or falling (1) as the active transition
  assign src_edge = irq_ctrl_r[`DBP_IRQ_EDGE_BIT] ? (src_d_r & ~src_s2_r)
                                                  : (src_s2_r & ~src_d_r);
  assign ev_set   = irq_ctrl_r[`DBP_IRQ_EN_BIT] & src_edge;   // see [R15] see [R6]

  // pending flag clears on a status read; a coincident event wins
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_stat_r <= 1'b0;
    end else if (ev_set) begin
      irq_stat_r <= 1'b1;                                      // see [R15]
    end else if (rd && i_wb_adr == `DBP_OFF_IRQ_STAT) begin
      irq_stat_r <= 1'b0;
    end
  end

  always @* begin
    rd_nxt = 32'h0000_0000;
    case (i_wb_adr)
      `DBP_OFF_B1_PORTA: rd_nxt[7:0] = b1_rd[7:0];
      `DBP_OFF_B1_PORTB: rd_nxt[7:0] = b1_rd[15:8];
      `DBP_OFF_B1_PORTC: rd_nxt[7:0] = b1_rd[23:16];          // see [R9]
      `DBP_OFF_B2_PORTA: rd_nxt[7:0] = b2_rd[7:0];
      `DBP_OFF_B2_PORTB: rd_nxt[7:0] = b2_rd[15:8];
      `DBP_OFF_B2_PORTC: rd_nxt[7:0] = b2_rd[23:16];
      `DBP_OFF_CTRL0:    rd_nxt[7:0] = ctrl0_r;
      `DBP_OFF_CTRL1:    rd_nxt[7:0] = ctrl1_r;
      `DBP_OFF_IRQ_STAT: rd_nxt[0]   = irq_stat_r;
      `DBP_OFF_IRQ_MASK: rd_nxt[0]   = irq_mask_r;
      `DBP_OFF_IRQ_CTRL: rd_nxt[1:0] = irq_ctrl_r;
      default:           rd_nxt      = 32'h0000_0000;
    endcase
  end

  // bus answer and registered pin and interrupt outputs
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wb_ack     <= 1'b0;
      o_wb_dat     <= 32'h0000_0000;
      o_bank1_dout <= 24'h00_0000;
      o_bank1_doe  <= 24'h00_0000;
      o_bank2_dout <= 24'h00_0000;
      o_bank2_doe  <= 24'h00_0000;
      o_irq        <= 1'b0;
    end else begin
      o_wb_ack     <= req;
      o_wb_dat     <= rd ? rd_nxt : 32'h0000_0000;
      o_bank1_dout <= b1_dout;                                 // see [R10]
      o_bank1_doe  <= b1_doe;                                  // see [R4]
      o_bank2_dout <= b2_dout;
      o_bank2_doe  <= b2_doe;
      o_irq        <= (irq_stat_r | ev_set) & irq_mask_r;
    end
  end

endmodule
`default_nettype wire

// *** testbench.sv ***
/* self-checking bench for the port block over classic wishbone
   assumes the checker is bound and the pin model stands at both banks */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0;
  logic [5:0]  adr = 6'h00;
  logic [31:0] wdat = 32'h0;
  logic [23:0] ext1 = 24'h967EA5, ext2 = 24'hFFFFFF;
  logic [7:0]  q;
  wire  [31:0] rdat;
  wire         ack, irq;
  wire  [23:0] p1, p2, d1, d2, e1, e2;
  int          bad_count = 0, comparisons = 0;
  dbp_top uut (.i_mclk(clk), .i_resetn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_bank1_pin(p1), .o_bank1_dout(d1),
    .o_bank1_doe(e1), .i_bank2_pin(p2), .o_bank2_dout(d2), .o_bank2_doe(e2), .o_irq(irq));
  dbp_pins m1 (.i_dout(d1), .i_doe(e1), .i_ext(ext1), .o_pin(p1));
  dbp_pins m2 (.i_dout(d2), .i_doe(e2), .i_ext(ext2), .o_pin(p2));
  initial forever #4 clk = ~clk;
  task complete_run;
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [23:0] e, input logic [23:0] s);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one classic cycle; released only at the edge where ack is seen
  task bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h0, d};
    n = 0;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 40);
    if (n == 40) begin
      bad_count++;
      complete_run;
    end
    q = rdat[7:0];
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task rd(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk("read data", {16'h0, e}, {16'h0, q});
  endtask
  task wt; repeat (3) @(posedge clk); endtask
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(6'h0C, 8'h9B);
    rd(6'h2C, 8'h9B);
    rd(6'h00, 8'hA5);
    rd(6'h04, 8'h7E);
    bus(1'b1, 6'h00, 8'h5A); wt; chk("doe1", 24'h0, e1);
    bus(1'b1, 6'h0C, 8'h8B); wt; chk("doe1", 24'h0000FF, e1);
    chk("dout1", 24'h5A, {16'h0, d1[7:0]});
    bus(1'b1, 6'h0C, 8'h9A); bus(1'b1, 6'h08, 8'hC3); wt;
    chk("doe1", 24'h0F0000, e1);
    chk("dout1", 24'hC3, {16'h0, d1[23:16]});
    rd(6'h08, 8'h93);
    bus(1'b1, 6'h2C, 8'h80); bus(1'b1, 6'h28, 8'h66); wt;
    chk("doe2", 24'hFFFFFF, e2);
    chk("dout2", 24'h66, {16'h0, d2[23:16]});
    chk("doe1", 24'h0F0000, e1);
    rd(6'h28, 8'h66);
    rd(6'h3C, 8'h00);
    ext1 <= 24'h967EA4;
    bus(1'b1, 6'h38, 8'h01); bus(1'b1, 6'h34, 8'h00); bus(1'b0, 6'h30, 8'h00);
    ext1 <= 24'h967EA5; wt; wt; chk("irq", 24'h0, {23'h0, irq});
    rd(6'h30, 8'h01);
    rd(6'h30, 8'h00);
    bus(1'b1, 6'h34, 8'h01); ext1 <= 24'h967EA4; wt;
    ext1 <= 24'h967EA5; wt; wt; chk("irq", 24'h1, {23'h0, irq});
    rd(6'h30, 8'h01); wt; chk("irq", 24'h0, {23'h0, irq});
    complete_run;
  end
  // the sequence needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    complete_run;
  end
endmodule
`default_nettype wire
